/* File: rtl/cms_pkg.sv */
package cms_pkg;
  localparam int unsigned DATA_W = 16;
  // routine selectors
  localparam logic [1:0] RT_DELETE  = 2'h0;
  localparam logic [1:0] RT_SETADDR = 2'h1;
  localparam logic [1:0] RT_READ    = 2'h2;
  // command codes
  localparam logic [15:0] EMPTY_HIGHEST_MATCH_CMD = 16'h042d;
  localparam logic [15:0] BACKGROUND_SET_CMD      = 16'h0619;
  localparam logic [15:0] FOREGROUND_SET_CMD      = 16'h0618;
  localparam logic [15:0] TARGET_ADDR_REG_CMD     = 16'h0220;
  localparam logic [15:0] TARGET_CHIP_SELECT_CMD  = 16'h0228;
  localparam logic [15:0] SELECT_ALL_CHIPS        = 16'hffff;
  localparam logic [15:0] DONT_CARE_WORD          = 16'h0000;
  // enable low widths and high gaps in clocks, 90 ns grade defaults
  localparam logic [3:0] SHORT_LOW  = 4'h2;
  localparam logic [3:0] MEDIUM_LOW = 4'h3;
  localparam logic [3:0] LONG_LOW   = 4'h4;
  localparam logic [3:0] HIGH_GAP   = 4'h1;
  localparam logic [3:0] COMPARE_GAP = 4'h4;
  // cycle length codes
  localparam logic [1:0] LEN_SHORT  = 2'h0;
  localparam logic [1:0] LEN_MEDIUM = 2'h1;
  localparam logic [1:0] LEN_LONG   = 2'h2;
  localparam logic [3:0] STEP_ONE   = 4'h1;
  localparam logic [2:0] SEG_LAST   = 3'h3;
endpackage

/* File: rtl/cms_cycle_if.sv */
interface cms_cycle_if;
  import cms_pkg::*;
  logic               start;
  logic               cmd;
  logic               wr;
  logic               cmp;
  logic [1:0]         len;
  logic [DATA_W-1:0]  wdata;
  logic               busy;
  logic               done;
  logic [DATA_W-1:0]  rdata;
  modport seq (output start, cmd, wr, cmp, len, wdata, input busy, done, rdata);
  modport eng (input start, cmd, wr, cmp, len, wdata, output busy, done, rdata);
endinterface

/* File: rtl/cms_cycle_engine.sv */
module cms_cycle_engine
  import cms_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  cms_cycle_if.eng   cyc,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_out,
  output logic                   enable_n_out,
  output logic                   cmd_n_out,
  output logic                   write_n_out,
  output logic                   cmp_n_out
);
  typedef enum logic [2:0] {CE_IDLE = 3'b001, CE_LOW = 3'b010, CE_HIGH = 3'b100} cms_ce_e;
  logic [DATA_W-1:0] dq_out_ff;
  logic              dq_oe_ff, enable_n_ff, cmd_n_ff, write_n_ff, cmp_n_ff;
  cms_ce_e           st_ff, nxt_st;
  logic [3:0]        cnt_ff, nxt_cnt;
  logic [DATA_W-1:0] rd_ff, nxt_rd, nxt_dq;
  logic              nxt_oe, nxt_en, nxt_cm, nxt_w, nxt_ec, cmp_ff, nxt_cmp;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_dq = dq_out_ff;
    nxt_oe = dq_oe_ff;
    nxt_en = enable_n_ff;
    nxt_cm = cmd_n_ff;
    nxt_w = write_n_ff;
    nxt_ec = cmp_n_ff;
    nxt_cmp = cmp_ff;
    unique case (st_ff)
      CE_IDLE: begin
        if (cyc.start) begin
          nxt_st = CE_LOW;
          nxt_en = 1'b0;
          nxt_cm = ~cyc.cmd;
          nxt_w = ~cyc.wr;
          nxt_ec = ~cyc.cmp;
          nxt_cmp = cyc.cmp;
          nxt_oe = cyc.wr;
          nxt_dq = cyc.wdata;
          unique case (cyc.len)
            LEN_LONG:   nxt_cnt = LONG_LOW - STEP_ONE;
            LEN_MEDIUM: nxt_cnt = MEDIUM_LOW - STEP_ONE;
            default:    nxt_cnt = SHORT_LOW - STEP_ONE;
          endcase
        end
      end
      CE_LOW: begin
        if (cnt_ff == 4'h0) begin
          nxt_st = CE_HIGH;
          nxt_en = 1'b1;
          nxt_rd = dq_in;
          nxt_cnt = (cmp_ff ? COMPARE_GAP : HIGH_GAP) - STEP_ONE;
        end else begin
          nxt_cnt = cnt_ff - STEP_ONE;
        end
      end
      CE_HIGH: begin
        if (cnt_ff == 4'h0) begin
          nxt_st = CE_IDLE;
          nxt_oe = 1'b0;
          nxt_cm = 1'b1;
          nxt_w = 1'b1;
          nxt_ec = 1'b1;
          nxt_cmp = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - STEP_ONE;
        end
      end
      default: nxt_st = CE_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= CE_IDLE;
      cnt_ff <= 4'h0;
      rd_ff <= 16'h0000;
      dq_out_ff <= 16'h0000;
      dq_oe_ff <= 1'b0;
      enable_n_ff <= 1'b1;
      cmd_n_ff <= 1'b1;
      write_n_ff <= 1'b1;
      cmp_n_ff <= 1'b1;
      cmp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      dq_out_ff <= nxt_dq;
      dq_oe_ff <= nxt_oe;
      enable_n_ff <= nxt_en;
      cmd_n_ff <= nxt_cm;
      write_n_ff <= nxt_w;
      cmp_n_ff <= nxt_ec;
      cmp_ff <= nxt_cmp;
    end
  end

  assign cyc.busy = (st_ff != CE_IDLE);
  assign cyc.done = (st_ff == CE_HIGH) && (cnt_ff == 4'h0);
  assign cyc.rdata = rd_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe_out = dq_oe_ff;
  assign enable_n_out = enable_n_ff;
  assign cmd_n_out = cmd_n_ff;
  assign write_n_out = write_n_ff;
  assign cmp_n_out = cmp_n_ff;

  enable_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(enable_n_ff) && !write_n_ff && !cmd_n_ff |-> !enable_n_ff [*2])
    else $error("enable low pulse too short");
endmodule

/* File: rtl/cam_maintenance_sequencer.sv */
// Function
// - delete opens with short dummy data write to segment 0.
// - delete writes three address words, compare enable low on third only.
// - delete ends with long command cycle carrying empty highest match code.
// - set-address and read-entries open with short background set command.
// - set-address targets address register then writes the address value.
// - set-address and read-entries end with short foreground set command.
// - read-entries targets chip select register then writes page address.
// - read-entries does four long data reads, segments 0 to 3 ascending.
// - two medium command reads give status bits 15:0 then 31:16.
// - read-entries reselects all chips via chip select before foreground restore.
// - repeated reads need no address reload; memory address auto-advances.
module cam_maintenance_sequencer
  import cms_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              req_valid_in,
  input  wire logic [1:0]        req_routine_in,
  input  wire logic [47:0]       req_key_in,
  input  wire logic [15:0]       req_value_in,
  output logic                   req_ready_out,
  output logic                   done_out,
  output logic [63:0]            entry_data_out,
  output logic [31:0]            entry_status_out,
  input  wire logic [15:0]       cam_dq_in,
  output logic [15:0]            cam_dq_out,
  output logic                   cam_dq_oe_out,
  output logic                   cam_enable_n_out,
  output logic                   cam_command_strobe_n_out,
  output logic                   cam_write_n_out,
  output logic                   cam_compare_latch_n_out
);
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001, SQ_ISSUE = 4'b0010, SQ_WAIT = 4'b0100, SQ_DONE = 4'b1000
  } cms_sq_e;

  cms_cycle_if cyc ();

  logic [15:0] dq_in_1_ff, dq_in_2_ff, dq_in_3_ff;
  cms_sq_e     st_ff, nxt_st;
  logic [1:0]  rt_ff, nxt_rt;
  logic [3:0]  step_ff, nxt_step;
  logic [47:0] key_ff, nxt_key;
  logic [15:0] val_ff, nxt_val;
  logic [63:0] data_ff, nxt_data;
  logic [31:0] stat_ff, nxt_stat;
  logic        done_ff, nxt_done;
  logic        s_cmd, s_wr, s_cmp, s_last;
  logic [1:0]  s_len;
  logic [15:0] s_data;
  logic [3:0]  last_step;

  // read data is off-domain pin data: two stages feed the engine, third stage only for the check
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dq_in_1_ff <= 16'h0000;
      dq_in_2_ff <= 16'h0000;
      dq_in_3_ff <= 16'h0000;
    end else begin
      dq_in_1_ff <= cam_dq_in;
      dq_in_2_ff <= dq_in_1_ff;
      dq_in_3_ff <= dq_in_2_ff;
    end
  end

  // per-step cycle description
  always_comb begin
    s_cmd = 1'b1;
    s_wr = 1'b1;
    s_cmp = 1'b0;
    s_len = LEN_SHORT;
    s_data = DONT_CARE_WORD;
    last_step = 4'h3;
    unique case (rt_ff)
      RT_DELETE: begin
        last_step = 4'h4;
        unique case (step_ff)
          4'h0: s_cmd = 1'b0;
          4'h1: begin s_cmd = 1'b0; s_data = key_ff[15:0]; end
          4'h2: begin s_cmd = 1'b0; s_data = key_ff[31:16]; end
          4'h3: begin s_cmd = 1'b0; s_data = key_ff[47:32]; s_cmp = 1'b1; end
          default: begin s_len = LEN_LONG; s_data = EMPTY_HIGHEST_MATCH_CMD; end
        endcase
      end
      RT_SETADDR: begin
        unique case (step_ff)
          4'h0: s_data = BACKGROUND_SET_CMD;
          4'h1: s_data = TARGET_ADDR_REG_CMD;
          4'h2: s_data = val_ff;
          default: s_data = FOREGROUND_SET_CMD;
        endcase
      end
      default: begin
        last_step = 4'hb;
        unique case (step_ff)
          4'h0: s_data = BACKGROUND_SET_CMD;
          4'h1: s_data = TARGET_CHIP_SELECT_CMD;
          4'h2: s_data = val_ff;
          4'h3, 4'h4, 4'h5, 4'h6: begin s_cmd = 1'b0; s_wr = 1'b0; s_len = LEN_LONG; end
          4'h7, 4'h8: begin s_wr = 1'b0; s_len = LEN_MEDIUM; end
          4'h9: s_data = TARGET_CHIP_SELECT_CMD;
          4'ha: s_data = SELECT_ALL_CHIPS;
          default: s_data = FOREGROUND_SET_CMD;
        endcase
      end
    endcase
    s_last = (step_ff == last_step);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_rt = rt_ff;
    nxt_step = step_ff;
    nxt_key = key_ff;
    nxt_val = val_ff;
    nxt_data = data_ff;
    nxt_stat = stat_ff;
    nxt_done = 1'b0;
    unique case (st_ff)
      SQ_IDLE: begin
        if (req_valid_in && (req_routine_in != 2'h3)) begin
          nxt_st = SQ_ISSUE;
          nxt_rt = req_routine_in;
          nxt_step = 4'h0;
          nxt_key = req_key_in;
          nxt_val = req_value_in;
        end
      end
      SQ_ISSUE: nxt_st = SQ_WAIT;
      SQ_WAIT: begin
        if (cyc.done) begin
          if (rt_ff == RT_READ) begin
            if (step_ff >= 4'h3 && step_ff <= 4'h6) begin
              nxt_data = {cyc.rdata, data_ff[63:16]};
            end
            if (step_ff == 4'h7 || step_ff == 4'h8) begin
              nxt_stat = {cyc.rdata, stat_ff[31:16]};
            end
          end
          if (s_last) begin
            nxt_st = SQ_DONE;
          end else begin
            nxt_st = SQ_ISSUE;
            nxt_step = step_ff + STEP_ONE;
          end
        end
      end
      SQ_DONE: begin
        nxt_st = SQ_IDLE;
        nxt_done = 1'b1;
      end
      default: nxt_st = SQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff <= SQ_IDLE;
      rt_ff <= RT_DELETE;
      step_ff <= 4'h0;
      key_ff <= 48'h0;
      val_ff <= 16'h0000;
      data_ff <= 64'h0;
      stat_ff <= 32'h0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      rt_ff <= nxt_rt;
      step_ff <= nxt_step;
      key_ff <= nxt_key;
      val_ff <= nxt_val;
      data_ff <= nxt_data;
      stat_ff <= nxt_stat;
      done_ff <= nxt_done;
    end
  end

  assign cyc.start = (st_ff == SQ_ISSUE);
  assign cyc.cmd = s_cmd;
  assign cyc.wr = s_wr;
  assign cyc.cmp = s_cmp;
  assign cyc.len = s_len;
  assign cyc.wdata = s_data;
  assign req_ready_out = (st_ff == SQ_IDLE);
  assign done_out = done_ff;
  assign entry_data_out = data_ff;
  assign entry_status_out = stat_ff;

  // no address reload needed between reads
  cms_cycle_engine u_eng (
    .clk_in       (core_clk_in),
    .rst_in       (rst_in),
    .cyc          (cyc),
    .dq_in        (dq_in_2_ff),
    .dq_out       (cam_dq_out),
    .dq_oe_out    (cam_dq_oe_out),
    .enable_n_out (cam_enable_n_out),
    .cmd_n_out    (cam_command_strobe_n_out),
    .write_n_out  (cam_write_n_out),
    .cmp_n_out    (cam_compare_latch_n_out)
  );

  sequence del_first_s;
    $fell(cam_enable_n_out) && rt_ff == RT_DELETE && step_ff == 4'h0;
  endsequence

  del_dummy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    del_first_s |-> cam_command_strobe_n_out && !cam_write_n_out && cam_compare_latch_n_out)
    else $error("delete dummy cycle wrong");
  del_compare_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !cam_compare_latch_n_out |-> rt_ff == RT_DELETE && step_ff == 4'h3 && cam_dq_out == key_ff[47:32])
    else $error("compare enable outside third key write");
  del_empty_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_DELETE && step_ff == 4'h4 |->
      !cam_command_strobe_n_out && cam_dq_out == EMPTY_HIGHEST_MATCH_CMD ##1 !cam_enable_n_out [*3])
    else $error("empty command cycle wrong");
  bg_select_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff != RT_DELETE && step_ff == 4'h0 |-> cam_dq_out == BACKGROUND_SET_CMD)
    else $error("background select missing");
  addr_target_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_SETADDR && step_ff == 4'h2 |-> cam_dq_out == val_ff)
    else $error("address value wrong");
  fg_restore_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff != RT_DELETE && s_last |-> cam_dq_out == FOREGROUND_SET_CMD)
    else $error("foreground restore missing");
  page_select_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_READ && step_ff == 4'h1 |-> cam_dq_out == TARGET_CHIP_SELECT_CMD)
    else $error("chip select target wrong");
  seg_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_READ && step_ff == 4'h3 |->
      cam_command_strobe_n_out && cam_write_n_out && !cam_dq_oe_out)
    else $error("segment read cycle wrong");
  status_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_READ && step_ff == 4'h7 |->
      !cam_command_strobe_n_out && cam_write_n_out ##1 !cam_enable_n_out [*2] ##1 cam_enable_n_out)
    else $error("status read not medium");
  all_chips_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(cam_enable_n_out) && rt_ff == RT_READ && step_ff == 4'ha |-> cam_dq_out == SELECT_ALL_CHIPS)
    else $error("select all missing");
  one_routine_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    st_ff != SQ_IDLE && !$past(rst_in) |=> $stable(rt_ff) || $past(st_ff) == SQ_IDLE)
    else $error("routine changed mid-run");
  // read word taken from second stage must equal third stage at cycle done
  sync_agree_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cyc.done && cam_write_n_out |-> cyc.rdata == dq_in_3_ff)
    else $error("read stages disagree at capture");
endmodule

/* File: test/cms_cam_model.sv */
module cms_cam_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] base_in,
  input  wire logic        enable_n_in,
  input  wire logic        cmd_n_in,
  input  wire logic        write_n_in,
  input  wire logic        cmp_n_in,
  input  wire logic [15:0] bus_in,
  output logic [15:0]      dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [22:0] log_q[$];
  logic [22:0] rec;
  logic [3:0]  low_cnt;
  logic [3:0]  rd_idx;
  logic [15:0] addr_reg;
  logic        tgt_addr;
  logic [15:0] last_word;
  logic [15:0] word;
  logic        drv;
  assign word = base_in ^ {addr_reg[11:0], rd_idx};
  assign drv = !enable_n_in && write_n_in;
  // answer reads
  // released bus shows inverse of last word
  assign dq_out = drv ? word : ~last_word;
  always @(posedge clk_in) begin
    if (rst_in) begin
      low_cnt <= 4'h0;
      rd_idx <= 4'h0;
      addr_reg <= 16'h0000;
      tgt_addr <= 1'b0;
      last_word <= 16'h0000;
    end else if (!enable_n_in) begin
      low_cnt <= low_cnt + 4'h1;
      rec = {cmd_n_in, write_n_in, cmp_n_in, low_cnt + 4'h1, write_n_in ? word : bus_in};
      if (drv) last_word <= word;
    end else if (low_cnt != 4'h0) begin
      log_q.push_back(rec);
      low_cnt <= 4'h0;
      if (!rec[22] && !rec[21]) begin
        if (rec[15:0] == 16'h0619) rd_idx <= 4'h0;
        if (tgt_addr) addr_reg <= rec[15:0];
        tgt_addr <= (rec[15:0] == 16'h0220);
      end else if (rec[21]) begin
        rd_idx <= rd_idx + 4'h1;
        if (rec[22] && rd_idx == 4'h3) addr_reg <= addr_reg + 16'h0001;
      end
    end
  end
endmodule

/* File: test/cam_maintenance_sequencer_test.sv */
module cam_maintenance_sequencer_test
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        req_valid_in = 1'b0;
  logic [1:0]  req_routine_in = 2'h0;
  logic [47:0] req_key_in = 48'h0;
  logic [15:0] req_value_in = 16'h0;
  logic        req_ready_out;
  logic        done_out;
  logic [63:0] entry_data_out;
  logic [31:0] entry_status_out;
  logic [15:0] cam_dq_out;
  logic        cam_dq_oe_out;
  logic        cam_enable_n_out;
  logic        cam_command_strobe_n_out;
  logic        cam_write_n_out;
  logic        cam_compare_latch_n_out;
  logic [15:0] dq_model;
  logic [15:0] dq_wire;
  logic [15:0] base = 16'h0;
  logic [15:0] exp_addr = 16'h0;
  logic [22:0] exp_q[$];
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #50 core_clk_in = ~core_clk_in;
  assign dq_wire = cam_dq_oe_out ? cam_dq_out : dq_model;
  cam_maintenance_sequencer cam_maintenance_sequencer_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_routine_in(req_routine_in), .req_key_in(req_key_in), .req_value_in(req_value_in),
    .req_ready_out(req_ready_out), .done_out(done_out), .entry_data_out(entry_data_out),
    .entry_status_out(entry_status_out), .cam_dq_in(dq_wire), .cam_dq_out(cam_dq_out),
    .cam_dq_oe_out(cam_dq_oe_out), .cam_enable_n_out(cam_enable_n_out),
    .cam_command_strobe_n_out(cam_command_strobe_n_out), .cam_write_n_out(cam_write_n_out),
    .cam_compare_latch_n_out(cam_compare_latch_n_out));
  cms_cam_model cms_cam_model_i (
    .clk_in(core_clk_in), .rst_in(rst_in), .base_in(base), .enable_n_in(cam_enable_n_out),
    .cmd_n_in(cam_command_strobe_n_out), .write_n_in(cam_write_n_out),
    .cmp_n_in(cam_compare_latch_n_out), .bus_in(dq_wire), .dq_out(dq_model));
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic add(input logic [2:0] ctl, input logic [3:0] low, input logic [15:0] d);
    exp_q.push_back({ctl, low, d});
  endtask
  function automatic logic [15:0] rword(input logic [15:0] a, input logic [3:0] i);
    return base ^ {a[11:0], i};
  endfunction
  task automatic run(input logic [1:0] rt, input logic [47:0] key, input logic [15:0] val);
    int n;
    logic [22:0] msk;
    base = 16'($urandom);
    exp_q.delete();
    case (rt)
      RT_DELETE: begin
        add(3'b101, SHORT_LOW, DONT_CARE_WORD);
        add(3'b101, SHORT_LOW, key[15:0]);
        add(3'b101, SHORT_LOW, key[31:16]);
        add(3'b100, SHORT_LOW, key[47:32]);
        add(3'b001, LONG_LOW, 16'h042d);
      end
      RT_SETADDR: begin
        add(3'b001, SHORT_LOW, 16'h0619);
        add(3'b001, SHORT_LOW, 16'h0220);
        add(3'b001, SHORT_LOW, val);
        add(3'b001, SHORT_LOW, 16'h0618);
      end
      default: begin
        add(3'b001, SHORT_LOW, 16'h0619);
        add(3'b001, SHORT_LOW, 16'h0228);
        add(3'b001, SHORT_LOW, val);
        for (int i = 0; i < 4; i++) add(3'b111, LONG_LOW, 16'h0);
        add(3'b011, MEDIUM_LOW, 16'h0);
        add(3'b011, MEDIUM_LOW, 16'h0);
        add(3'b001, SHORT_LOW, 16'h0228);
        add(3'b001, SHORT_LOW, 16'hffff);
        add(3'b001, SHORT_LOW, 16'h0618);
      end
    endcase
    @(posedge core_clk_in);
    #1;
    req_valid_in = 1'b1;
    req_routine_in = rt;
    req_key_in = key;
    req_value_in = val;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    @(posedge core_clk_in);
    #1;
    // busy: further requests must be refused
    check(req_ready_out, 1'b0, "busy ready");
    req_routine_in = 2'($urandom_range(0, 2));
    req_key_in = 48'({$urandom, $urandom});
    repeat (10) @(posedge core_clk_in);
    #1;
    req_valid_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 400) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check(done_out, 1'b1, "done");
    check(req_ready_out, 1'b1, "idle ready");
    @(posedge core_clk_in);
    #1;
    check(done_out, 1'b0, "done pulse");
    check({cam_enable_n_out, cam_command_strobe_n_out, cam_write_n_out, cam_compare_latch_n_out,
           cam_dq_oe_out}, 5'b11110, "idle strobes");
    check(cms_cam_model_i.log_q.size(), exp_q.size(), "cycle count");
    for (int i = 0; i < exp_q.size() && i < cms_cam_model_i.log_q.size(); i++) begin
      msk = exp_q[i][21] ? 23'h7f0000 : 23'h7fffff;
      check(cms_cam_model_i.log_q[i] & msk, exp_q[i] & msk, "bus cycle");
    end
    cms_cam_model_i.log_q.delete();
    if (rt == RT_SETADDR) exp_addr = val;
    if (rt == RT_READ) begin
      check(entry_data_out, {rword(exp_addr, 4'h3), rword(exp_addr, 4'h2), rword(exp_addr, 4'h1),
            rword(exp_addr, 4'h0)}, "entry");
      exp_addr = exp_addr + 16'h0001;
      check(entry_status_out, {rword(exp_addr, 4'h5), rword(exp_addr, 4'h4)}, "status");
    end
  endtask
  initial begin
    void'($urandom(32'hd529));
    repeat (20) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    run(RT_DELETE, 48'h0, 16'h0);
    run(RT_DELETE, 48'hffff_ffff_ffff, 16'hffff);
    run(RT_SETADDR, 48'h0, 16'h1fff);
    for (int k = 0; k < 6; k++) begin
      run(RT_DELETE, 48'({$urandom, $urandom}), 16'h0);
      run(RT_SETADDR, 48'h0, 16'h1000 | 16'($urandom_range(0, 4095)));
      run(RT_READ, 48'h0, 16'($urandom_range(0, 255)));
      run(RT_READ, 48'h0, 16'($urandom_range(0, 255)));
    end
    @(posedge core_clk_in);
    #1;
    req_routine_in = 2'h3;
    req_valid_in = 1'b1;
    repeat (40) @(posedge core_clk_in);
    #1;
    req_valid_in = 1'b0;
    check(cms_cam_model_i.log_q.size(), 0, "ignored routine");
    conclude();
  end
endmodule
